/* File: rtl/udc_defs.svh */
/*
 * Constants of the USB device control and endpoint-configuration block:
 * register addresses, bit positions, reset values, field layouts,
 * transfer-type codes and timing figures.
 * Assumes a 20 MHz system clock and an 8-bit special function register bus.
 */
// Functional notes
// - bit 7 routes data pins: USB or GPIO
// - suspend fall sets wake flag, firmware clears
// - transceiver power-down active high, 5 us settle
// - bit 2 write 1 powers regulator down
// - bit 0 write 1 powers PLL down
// - request flags bits 3..0, upper bits zero
// - device enable bit 6 enables controller
// - remote wake bit 5 drives resume signalling
// - bit 4 stalls the control endpoint request
// - bit 2 reports suspend state
// - reset ready when PLL and device resets low
// - bit 0 stops the 48 MHz clock
// - state register shows interface, alternate, endpoint
// - ready flag bit 7, cleared by read
// - done flag bit 6 after loading
// - each data write passes one byte, five total
// - bytes one to four configure endpoints 1..4
// - type codes: interrupt, bulk, isochronous, control
// - fifth byte holds OUT types, endpoints 1..4
// - bit 6 holds OUT buffer access
// - bit 3 holds IN buffer access
`ifndef UDC_DEFS_SVH
`define UDC_DEFS_SVH

`define UDC_ADDR_STD_FLAGS 8'h9d
`define UDC_ADDR_DEV_CTRL 8'hb1
`define UDC_ADDR_DEV_STATE 8'hb2
`define UDC_ADDR_CFG_STATUS 8'hb3
`define UDC_ADDR_CFG_DATA 8'hb4
`define UDC_ADDR_PHY_CTRL 8'hda

`define UDC_RST_STD_FLAGS 8'h00
`define UDC_RST_DEV_CTRL 8'h00
`define UDC_RST_CFG_DATA 8'h00
`define UDC_RST_PHY_CTRL 8'h80
`define UDC_ZERO_BYTE 8'h00

// usb phy control register
`define UDC_PC_PIN_SEL 7
`define UDC_PC_OUT_HOLD 6
`define UDC_PC_WAKE 5
`define UDC_PC_REG_PD 2
`define UDC_PC_XCVR_PD 1
`define UDC_PC_PLL_PD 0

// device control register
`define UDC_DC_ENABLE 6
`define UDC_DC_RWAKE 5
`define UDC_DC_STALL 4
`define UDC_DC_IN_HOLD 3
`define UDC_DC_SUSP 2
`define UDC_DC_RST_RDY 1
`define UDC_DC_CLK_GATE 0

// standard request flags
`define UDC_SF_ADDR 3
`define UDC_SF_FSET 2
`define UDC_SF_FCLR 1
`define UDC_SF_CONF 0
`define UDC_SF_MASK 8'h0f

// config load status
`define UDC_CS_READY 7
`define UDC_CS_DONE 6

// endpoint byte fields: low bit of each two-bit field
`define UDC_EB_CONF 6
`define UDC_EB_IF 4
`define UDC_EB_ALT 2
`define UDC_EB_TYPE 0

`define UDC_XFER_CONTROL 2'b00
`define UDC_XFER_ISO 2'b01
`define UDC_XFER_BULK 2'b10
`define UDC_XFER_INTR 2'b11

`define UDC_CFG_BYTES 5
`define UDC_CFG_LAST 3'd4
`define UDC_CFG_LOAD_CYC 4'd2

`define UDC_CLK_PERIOD_NS 50
`define UDC_PHY_STABLE_NS 5000
`define UDC_PHY_STABLE_CYC \
    ((`UDC_PHY_STABLE_NS + `UDC_CLK_PERIOD_NS - 1) / `UDC_CLK_PERIOD_NS)

`endif

/* File: rtl/udc_pkg.sv */
/*
 * Types shared by the USB device control block.
 * Assumes udc_defs.svh is on the include path.
 */
`include "udc_defs.svh"

package udc_pkg;
    typedef logic [7:0] udc_byte_t;

    typedef enum logic [1:0] {
        UDC_XFER_CTRL = `UDC_XFER_CONTROL,
        UDC_XFER_ISOC = `UDC_XFER_ISO,
        UDC_XFER_BLK = `UDC_XFER_BULK,
        UDC_XFER_INT = `UDC_XFER_INTR
    } udc_xfer_e;

    typedef enum logic [2:0] {
        UDC_CFG_IDLE = 3'b001,
        UDC_CFG_BUSY = 3'b010,
        UDC_CFG_DONE = 3'b100
    } udc_cfg_state_e;
endpackage

/* File: rtl/udc_epcfg.sv */
/*
 * USB device controller control, status and endpoint-configuration logic.
 * Registers sit on the special function register bus: one write strobe,
 * one read strobe, read data registered one cycle after the read strobe.
 * Assumes all inputs are synchronous to clock_i and that status inputs
 * from the serial engine are single-cycle pulses or levels as named.
 */
`include "udc_defs.svh"

module udc_epcfg #(
    parameter int PHY_STABLE_CYC = `UDC_PHY_STABLE_CYC,
    parameter logic [3:0] CFG_LOAD_CYC = `UDC_CFG_LOAD_CYC
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire udc_pkg::udc_byte_t sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output udc_pkg::udc_byte_t sfr_rdata_o,
    input wire logic suspend_i,
    input wire logic pll_rst_i,
    input wire logic dev_rst_i,
    input wire logic set_address_seen_i,
    input wire logic set_feature_seen_i,
    input wire logic clear_feature_seen_i,
    input wire logic set_config_seen_i,
    input wire logic [1:0] cur_interface_i,
    input wire logic cur_alternate_i,
    input wire logic [2:0] cur_endpoint_i,
    output logic pin_function_select_o,
    output logic out_buffer_access_hold_o,
    output logic cpu_wake_o,
    output logic regulator_power_down_o,
    output logic transceiver_power_down_o,
    output logic phy_ready_o,
    output logic pll_power_off_o,
    output logic device_enable_o,
    output logic remote_wake_request_o,
    output logic ctrl_stall_o,
    output logic in_buffer_access_hold_o,
    output logic usb_clock_gate_o,
    output udc_pkg::udc_byte_t ep_cfg_value_o,
    output udc_pkg::udc_byte_t ep_interface_o,
    output udc_pkg::udc_byte_t ep_alternate_o,
    output logic [3:0] ep_in_bulk_o,
    output logic [3:0] ep_in_intr_o,
    output logic [3:0] ep_in_iso_o,
    output logic [3:0] ep_out_bulk_o,
    output logic [3:0] ep_out_intr_o,
    output logic [3:0] ep_out_iso_o,
    output logic config_complete_o
);
    import udc_pkg::*;

    function automatic udc_xfer_e xfer_decode(input logic [1:0] code);
        udc_xfer_e t;
        t = UDC_XFER_CTRL;
        unique case (code)
            `UDC_XFER_INTR: t = UDC_XFER_INT;
            `UDC_XFER_BULK: t = UDC_XFER_BLK;
            `UDC_XFER_ISO: t = UDC_XFER_ISOC;
            `UDC_XFER_CONTROL: t = UDC_XFER_CTRL;
        endcase
        return t;
    endfunction

    // ---------------- register state ----------------
    udc_byte_t phy_ctrl, next_phy_ctrl;
    udc_byte_t dev_ctrl, next_dev_ctrl;
    udc_byte_t std_flags, next_std_flags;
    udc_byte_t dev_state, next_dev_state;
    logic susp_q, next_susp_q;
    logic rst_rdy, next_rst_rdy;

    logic wr_phy, wr_dev, wr_std, wr_cfg, rd_cfg_status;
    assign wr_phy = sfr_wr_i && (sfr_addr_i == `UDC_ADDR_PHY_CTRL);
    assign wr_dev = sfr_wr_i && (sfr_addr_i == `UDC_ADDR_DEV_CTRL);
    assign wr_std = sfr_wr_i && (sfr_addr_i == `UDC_ADDR_STD_FLAGS);
    assign wr_cfg = sfr_wr_i && (sfr_addr_i == `UDC_ADDR_CFG_DATA);
    assign rd_cfg_status = sfr_rd_i &&
        (sfr_addr_i == `UDC_ADDR_CFG_STATUS);

    always_comb begin
        next_phy_ctrl = phy_ctrl;
        next_dev_ctrl = dev_ctrl;
        next_std_flags = std_flags;
        next_susp_q = suspend_i;
        next_rst_rdy = !pll_rst_i && !dev_rst_i;
        next_dev_state = `UDC_ZERO_BYTE;
        next_dev_state[5:4] = cur_interface_i;
        next_dev_state[3] = cur_alternate_i;
        next_dev_state[2:0] = cur_endpoint_i;
        if (wr_phy) begin
            next_phy_ctrl[`UDC_PC_PIN_SEL] = sfr_wdata_i[`UDC_PC_PIN_SEL];
            next_phy_ctrl[`UDC_PC_OUT_HOLD] = sfr_wdata_i[`UDC_PC_OUT_HOLD];
            next_phy_ctrl[`UDC_PC_REG_PD] = sfr_wdata_i[`UDC_PC_REG_PD];
            next_phy_ctrl[`UDC_PC_XCVR_PD] = sfr_wdata_i[`UDC_PC_XCVR_PD];
            next_phy_ctrl[`UDC_PC_PLL_PD] = sfr_wdata_i[`UDC_PC_PLL_PD];
            // wake flag: writing 0 clears, writing 1 keeps
            next_phy_ctrl[`UDC_PC_WAKE] = phy_ctrl[`UDC_PC_WAKE] &&
                sfr_wdata_i[`UDC_PC_WAKE];
        end
        if (susp_q && !suspend_i) begin
            next_phy_ctrl[`UDC_PC_WAKE] = 1'b1;
        end
        if (wr_dev) begin
            next_dev_ctrl[`UDC_DC_ENABLE] = sfr_wdata_i[`UDC_DC_ENABLE];
            next_dev_ctrl[`UDC_DC_RWAKE] = sfr_wdata_i[`UDC_DC_RWAKE];
            next_dev_ctrl[`UDC_DC_STALL] = sfr_wdata_i[`UDC_DC_STALL];
            next_dev_ctrl[`UDC_DC_IN_HOLD] = sfr_wdata_i[`UDC_DC_IN_HOLD];
            next_dev_ctrl[`UDC_DC_CLK_GATE] =
                sfr_wdata_i[`UDC_DC_CLK_GATE];
        end
        if (wr_std) begin
            next_std_flags = std_flags & sfr_wdata_i & `UDC_SF_MASK;
        end
        // hardware set wins over a firmware clear
        if (set_address_seen_i) begin
            next_std_flags[`UDC_SF_ADDR] = 1'b1;
        end
        if (set_feature_seen_i) begin
            next_std_flags[`UDC_SF_FSET] = 1'b1;
        end
        if (clear_feature_seen_i) begin
            next_std_flags[`UDC_SF_FCLR] = 1'b1;
        end
        if (set_config_seen_i) begin
            next_std_flags[`UDC_SF_CONF] = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            phy_ctrl <= `UDC_RST_PHY_CTRL;
            dev_ctrl <= `UDC_RST_DEV_CTRL;
            std_flags <= `UDC_RST_STD_FLAGS;
            dev_state <= `UDC_ZERO_BYTE;
            susp_q <= 1'b0;
            rst_rdy <= 1'b0;
        end else begin
            phy_ctrl <= next_phy_ctrl;
            dev_ctrl <= next_dev_ctrl;
            std_flags <= next_std_flags;
            dev_state <= next_dev_state;
            susp_q <= next_susp_q;
            rst_rdy <= next_rst_rdy;
        end
    end

    // ---------------- transceiver settle timer ----------------
    logic [$clog2(PHY_STABLE_CYC+1)-1:0] phy_cnt, next_phy_cnt;

    always_comb begin
        next_phy_cnt = phy_cnt;
        if (next_phy_ctrl[`UDC_PC_XCVR_PD]) begin
            next_phy_cnt = '0;
        end else if (phy_cnt != PHY_STABLE_CYC[$bits(phy_cnt)-1:0]) begin
            next_phy_cnt = phy_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            phy_cnt <= '0;
        end else begin
            phy_cnt <= next_phy_cnt;
        end
    end

    // ---------------- endpoint information loader ----------------
    udc_cfg_state_e cfg_state, next_cfg_state;
    udc_byte_t cfg_mem [`UDC_CFG_BYTES];
    udc_byte_t next_cfg_mem [`UDC_CFG_BYTES];
    udc_byte_t cfg_data, next_cfg_data;
    logic [2:0] cfg_idx, next_cfg_idx;
    logic [3:0] cfg_wait, next_cfg_wait;
    logic cfg_ready, next_cfg_ready;
    logic cfg_done, next_cfg_done;
    logic cfg_accept;

    always_comb begin
        next_cfg_state = cfg_state;
        next_cfg_mem = cfg_mem;
        next_cfg_data = cfg_data;
        next_cfg_idx = cfg_idx;
        next_cfg_wait = cfg_wait;
        next_cfg_done = cfg_done;
        next_cfg_ready = cfg_ready && !rd_cfg_status;
        cfg_accept = 1'b0;
        unique case (cfg_state)
            UDC_CFG_IDLE: begin
                if (wr_cfg) begin
                    cfg_accept = 1'b1;
                end
            end
            UDC_CFG_BUSY: begin
                if (cfg_wait == 4'd0) begin
                    next_cfg_ready = 1'b1; // set wins over read clear
                    if (cfg_idx == `UDC_CFG_LAST) begin
                        next_cfg_done = 1'b1;
                        next_cfg_state = UDC_CFG_DONE;
                    end else begin
                        next_cfg_idx = cfg_idx + 3'd1;
                        next_cfg_state = UDC_CFG_IDLE;
                    end
                end else begin
                    next_cfg_wait = cfg_wait - 4'd1;
                end
            end
            UDC_CFG_DONE: begin
                if (wr_cfg) begin
                    // a new write restarts the sequence
                    next_cfg_done = 1'b0;
                    next_cfg_idx = 3'd0;
                    cfg_accept = 1'b1;
                end
            end
        endcase
        if (cfg_accept) begin
            // one byte per write
            next_cfg_data = sfr_wdata_i;
            next_cfg_mem[next_cfg_idx] = sfr_wdata_i;
            next_cfg_wait = CFG_LOAD_CYC;
            next_cfg_state = UDC_CFG_BUSY;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg_state <= UDC_CFG_IDLE;
            for (int i = 0; i < `UDC_CFG_BYTES; i++) begin
                cfg_mem[i] <= `UDC_RST_CFG_DATA;
            end
            cfg_data <= `UDC_RST_CFG_DATA;
            cfg_idx <= 3'd0;
            cfg_wait <= 4'd0;
            cfg_ready <= 1'b0;
            cfg_done <= 1'b0;
        end else begin
            cfg_state <= next_cfg_state;
            cfg_mem <= next_cfg_mem;
            cfg_data <= next_cfg_data;
            cfg_idx <= next_cfg_idx;
            cfg_wait <= next_cfg_wait;
            cfg_ready <= next_cfg_ready;
            cfg_done <= next_cfg_done;
        end
    end

    // ---------------- per-endpoint decode ----------------
    udc_byte_t next_ep_conf, next_ep_if, next_ep_alt;
    logic [3:0] next_in_bulk, next_in_intr, next_in_iso;
    logic [3:0] next_out_bulk, next_out_intr, next_out_iso;

    for (genvar e = 0; e < 4; e++) begin : g_ep
        udc_xfer_e in_t, out_t;
        assign in_t = xfer_decode(
            next_cfg_mem[e][`UDC_EB_TYPE +: 2]);
        assign out_t = xfer_decode(
            next_cfg_mem[`UDC_CFG_LAST][6-2*e +: 2]);
        assign next_ep_conf[2*e +: 2] = next_cfg_mem[e][`UDC_EB_CONF +: 2];
        assign next_ep_if[2*e +: 2] = next_cfg_mem[e][`UDC_EB_IF +: 2];
        assign next_ep_alt[2*e +: 2] = next_cfg_mem[e][`UDC_EB_ALT +: 2];
        assign next_in_bulk[e] = (in_t == UDC_XFER_BLK);
        assign next_in_intr[e] = (in_t == UDC_XFER_INT);
        assign next_in_iso[e] = (in_t == UDC_XFER_ISOC);
        assign next_out_bulk[e] = (out_t == UDC_XFER_BLK);
        assign next_out_intr[e] = (out_t == UDC_XFER_INT);
        assign next_out_iso[e] = (out_t == UDC_XFER_ISOC);
    end

    // ---------------- register read ----------------
    function automatic udc_byte_t reg_read(input logic [7:0] addr);
        udc_byte_t d;
        d = `UDC_ZERO_BYTE;
        unique case (addr)
            `UDC_ADDR_PHY_CTRL: d = phy_ctrl;
            `UDC_ADDR_STD_FLAGS: d = std_flags & `UDC_SF_MASK;
            `UDC_ADDR_DEV_CTRL: begin
                d = dev_ctrl;
                d[`UDC_DC_SUSP] = susp_q;
                d[`UDC_DC_RST_RDY] = rst_rdy;
            end
            `UDC_ADDR_DEV_STATE: d = dev_state;
            `UDC_ADDR_CFG_STATUS: begin
                d[`UDC_CS_READY] = cfg_ready;
                d[`UDC_CS_DONE] = cfg_done;
            end
            `UDC_ADDR_CFG_DATA: d = cfg_data;
            default: d = `UDC_ZERO_BYTE;
        endcase
        return d;
    endfunction

    udc_byte_t next_rdata;
    always_comb begin
        next_rdata = sfr_rdata_o;
        if (sfr_rd_i) begin
            next_rdata = reg_read(sfr_addr_i);
        end
    end

    // ---------------- output flops ----------------
    logic ena_next;
    assign ena_next = next_dev_ctrl[`UDC_DC_ENABLE];

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sfr_rdata_o <= `UDC_ZERO_BYTE;
            pin_function_select_o <=
                1'(`UDC_RST_PHY_CTRL >> `UDC_PC_PIN_SEL);
            out_buffer_access_hold_o <= 1'b0;
            cpu_wake_o <= 1'b0;
            regulator_power_down_o <= 1'b0;
            transceiver_power_down_o <= 1'b0;
            phy_ready_o <= 1'b0;
            pll_power_off_o <= 1'b0;
            device_enable_o <= 1'b0;
            remote_wake_request_o <= 1'b0;
            ctrl_stall_o <= 1'b0;
            in_buffer_access_hold_o <= 1'b0;
            usb_clock_gate_o <= 1'b0;
            ep_cfg_value_o <= `UDC_ZERO_BYTE;
            ep_interface_o <= `UDC_ZERO_BYTE;
            ep_alternate_o <= `UDC_ZERO_BYTE;
            ep_in_bulk_o <= 4'h0;
            ep_in_intr_o <= 4'h0;
            ep_in_iso_o <= 4'h0;
            ep_out_bulk_o <= 4'h0;
            ep_out_intr_o <= 4'h0;
            ep_out_iso_o <= 4'h0;
            config_complete_o <= 1'b0;
        end else begin
            sfr_rdata_o <= next_rdata;
            pin_function_select_o <= next_phy_ctrl[`UDC_PC_PIN_SEL];
            out_buffer_access_hold_o <= next_phy_ctrl[`UDC_PC_OUT_HOLD];
            cpu_wake_o <= next_phy_ctrl[`UDC_PC_WAKE];
            regulator_power_down_o <= next_phy_ctrl[`UDC_PC_REG_PD];
            transceiver_power_down_o <= next_phy_ctrl[`UDC_PC_XCVR_PD];
            phy_ready_o <= !next_phy_ctrl[`UDC_PC_XCVR_PD] &&
                (next_phy_cnt == PHY_STABLE_CYC[$bits(phy_cnt)-1:0]);
            pll_power_off_o <= next_phy_ctrl[`UDC_PC_PLL_PD];
            device_enable_o <= ena_next;
            // resume and stall act only on an enabled controller
            remote_wake_request_o <= ena_next &&
                next_dev_ctrl[`UDC_DC_RWAKE];
            ctrl_stall_o <= ena_next &&
                next_dev_ctrl[`UDC_DC_STALL];
            in_buffer_access_hold_o <= next_dev_ctrl[`UDC_DC_IN_HOLD];
            usb_clock_gate_o <= next_dev_ctrl[`UDC_DC_CLK_GATE];
            ep_cfg_value_o <= next_ep_conf;
            ep_interface_o <= next_ep_if;
            ep_alternate_o <= next_ep_alt;
            ep_in_bulk_o <= next_in_bulk;
            ep_in_intr_o <= next_in_intr;
            ep_in_iso_o <= next_in_iso;
            ep_out_bulk_o <= next_out_bulk;
            ep_out_intr_o <= next_out_intr;
            ep_out_iso_o <= next_out_iso;
            config_complete_o <= next_cfg_done;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    chk_pin_select: assert property (
        wr_phy |=> pin_function_select_o == $past(sfr_wdata_i[7]))
        else $error("pin select does not follow write");

    chk_wake_flag: assert property (
        (susp_q && !suspend_i) |=> cpu_wake_o)
        else $error("wake flag not set on suspend release");

    chk_phy_settle: assert property (
        $rose(phy_ready_o) |-> !transceiver_power_down_o &&
            $past(transceiver_power_down_o) == 1'b0)
        else $error("transceiver ready while powered down");

    chk_power_bits: assert property (
        wr_phy |=> regulator_power_down_o == $past(sfr_wdata_i[2]) &&
            pll_power_off_o == $past(sfr_wdata_i[0]))
        else $error("power-down bits do not follow write");

    chk_std_flag_set: assert property (
        set_address_seen_i |=> std_flags[3] ##1 (std_flags[7:4] == 4'h0))
        else $error("address request flag not raised");

    chk_stall_gate: assert property (
        ctrl_stall_o |-> device_enable_o && dev_ctrl[4])
        else $error("stall without enable");

    chk_reset_ready: assert property (
        (pll_rst_i || dev_rst_i) |=> !rst_rdy)
        else $error("reset ready with a reset asserted");

    chk_ready_clear: assert property (
        (rd_cfg_status && cfg_ready && !cfg_state[1]) |=> !cfg_ready)
        else $error("ready flag not cleared by read");

    chk_load_ready: assert property (
        (cfg_accept && CFG_LOAD_CYC == 4'd2) |=> !cfg_ready[*3] ##1
            cfg_ready)
        else $error("ready flag late after byte write");

    chk_done_fifth: assert property (
        $rose(cfg_done) |-> $past(cfg_idx) == 3'd4)
        else $error("done before fifth byte");

    chk_state_view: assert property (
        (sfr_rd_i && sfr_addr_i == `UDC_ADDR_DEV_STATE) |=>
            sfr_rdata_o[7:6] == 2'b00 &&
            sfr_rdata_o[5:0] == $past(dev_state[5:0]))
        else $error("state register read mismatch");
endmodule

/* File: testbench/udc_sie_model.sv */
/* Serial-engine stand-in facing the control block.
   Assumes the bench calls its tasks; it changes only at falling edges. */
module udc_sie_model (
    input wire logic clock_i,
    output logic suspend_o,
    output logic pll_rst_o,
    output logic dev_rst_o,
    output logic [3:0] req_o,
    output logic [5:0] state_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        suspend_o = 1'b0;
        pll_rst_o = 1'b1;
        dev_rst_o = 1'b1;
        req_o = 4'h0;
        state_o = 6'h00;
    end
    // one-cycle request pulses: address, set, clear, configuration
    task automatic pulse(input logic [3:0] m);
        @(negedge clock_i) req_o = m;
        @(negedge clock_i) req_o = 4'h0;
    endtask
    task automatic levels(input logic s, input logic p, input logic d,
                          input logic [5:0] st);
        @(negedge clock_i);
        suspend_o = s;
        pll_rst_o = p;
        dev_rst_o = d;
        state_o = st;
    endtask
endmodule

/* File: testbench/tb_top.sv */
/* Register-level bench for the USB control and endpoint-config block.
   Assumes the design's one-cycle strobe protocol and a 20 MHz clock. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import udc_pkg::*;
    logic clk, rst, wr, rd, dn;
    logic [7:0] addr, wd, q, cv, ci, ca;
    logic [11:0] o;
    logic [3:0] ib, ii, is, ob, oi, os, rq;
    logic sp, pr, dr;
    logic [5:0] st;
    int failures = 0;
    int total_checks = 0;
    logic [7:0] bytes [5] = '{8'hc0, 8'h11, 8'ha6, 8'h7b, 8'h1b};
    udc_sie_model far (.clock_i(clk), .suspend_o(sp), .pll_rst_o(pr),
        .dev_rst_o(dr), .req_o(rq), .state_o(st));
    udc_epcfg #(.PHY_STABLE_CYC(4), .CFG_LOAD_CYC(4'd2)) dut (
        .clock_i(clk), .srst_i(rst), .sfr_addr_i(addr),
        .sfr_wdata_i(wd), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(q),
        .suspend_i(sp), .pll_rst_i(pr), .dev_rst_i(dr),
        .set_address_seen_i(rq[3]), .set_feature_seen_i(rq[2]),
        .clear_feature_seen_i(rq[1]), .set_config_seen_i(rq[0]),
        .cur_interface_i(st[5:4]), .cur_alternate_i(st[3]),
        .cur_endpoint_i(st[2:0]), .pin_function_select_o(o[11]),
        .out_buffer_access_hold_o(o[10]), .cpu_wake_o(o[9]),
        .regulator_power_down_o(o[8]), .transceiver_power_down_o(o[7]),
        .phy_ready_o(o[6]), .pll_power_off_o(o[5]),
        .device_enable_o(o[4]), .remote_wake_request_o(o[3]),
        .ctrl_stall_o(o[2]), .in_buffer_access_hold_o(o[1]),
        .usb_clock_gate_o(o[0]), .ep_cfg_value_o(cv),
        .ep_interface_o(ci), .ep_alternate_o(ca), .ep_in_bulk_o(ib),
        .ep_in_intr_o(ii), .ep_in_iso_o(is), .ep_out_bulk_o(ob),
        .ep_out_intr_o(oi), .ep_out_iso_o(os), .config_complete_o(dn));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk) wr = 1'b0;
    endtask
    task automatic rd_raw(input logic [7:0] a);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk) rd = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd_raw(a);
        chk(q, e);
    endtask
    // one config byte: wait ready high, then ready low
    task automatic cfg(input logic [7:0] b, input logic [7:0] e);
        int n;
        wrt(8'hb4, b);
        n = 0;
        do begin
            rd_raw(8'hb3);
            n++;
        end while (q[7] !== 1'b1 && n < 20);
        chk(q[7], 1'b1);
        rdc(8'hb3, e);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #(3000 * 50);
        failures++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wd = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(o, 12'h800);
        rdc(8'hda, 8'h80);
        rdc(8'h9d, 8'h00);
        rdc(8'hb1, 8'h00);
        rdc(8'hb3, 8'h00);
        rdc(8'h55, 8'h00);
        chk(o[6], 1'b1);
        wrt(8'hda, 8'h47);
        chk(o, 12'h5a0);
        rdc(8'hda, 8'h47);
        wrt(8'hda, 8'h80);
        chk(o[6], 1'b0);
        repeat (8) @(negedge clk);
        chk(o[6], 1'b1);
        far.levels(1'b1, 1'b0, 1'b0, 6'h2d);
        far.levels(1'b0, 1'b0, 1'b0, 6'h2d);
        repeat (2) @(negedge clk);
        chk(o[9], 1'b1);
        rdc(8'hda, 8'ha0);
        wrt(8'hda, 8'h80);
        chk(o[9], 1'b0);
        rdc(8'hb2, 8'h2d);
        rdc(8'hb1, 8'h02);
        for (int i = 0; i < 4; i++) begin
            far.pulse(4'h1 << i);
            rdc(8'h9d, 8'h01 << i);
            wrt(8'h9d, 8'h00);
        end
        far.levels(1'b1, 1'b0, 1'b1, 6'h00);
        wrt(8'hb1, 8'h79);
        chk(o[4:0], 5'h1f);
        rdc(8'hb1, 8'h7d);
        wrt(8'hb1, 8'h39);
        chk(o[4:0], 5'h03);
        for (int i = 0; i < 5; i++) begin
            chk(dn, 1'b0);
            cfg(bytes[i], (i == 4) ? 8'h40 : 8'h00);
        end
        chk(dn, 1'b1);
        rdc(8'hb3, 8'h40);
        chk({cv, ci}, 16'h63e4);
        chk({ca, ib, ii}, 16'h9048);
        chk({is, ob, oi, os}, 16'h2482);
        wrt(8'hb4, 8'h00);
        @(negedge clk);
        chk(dn, 1'b0);
        final_report();
    end
endmodule
